// ---- hw/pfm_pin_mux.sv ----
// Notes on behaviour
// (R1) after reset every pin is an input with its driver off
// (R2) port 0: pins 0 and 4 input only, pins 1-3 per-bit direction and pull-up
// (R3) ports 1,2,3,5 and port 6 upper: per-pin direction, pull-up only as input
// (R4) port 4 direction is one bit for all eight pins, pull-up as input
// (R5) falling edge on a port 4 input pin sets the key-return flag
// (R6) port 6 lower pins open-drain, pull-ups fixed by mask option
// (R7) software sets feedback-resistor-disable before using sub-osc pin as input
// (R8) port 1 pin used as analog input has its pull-up forced off
// (R9) first external interrupt fires on rising, falling or both edges
// (R10) port 4 carries low address and data during external accesses
// (R11) port 5 carries high address during external accesses
// (R12) address latch strobe on port 6 captures address on ports 4 and 5
// (R13) separate read and write strobes on two port 6 pins
// (R14) wait input on port 6 stretches the running external access
// (R15) port 2 gives automatic transfer strobe out and busy input
// (R16) serial channel 0 data pins become open-drain bus lines in bus mode
// (R17) serial clock pins driven when master, received otherwise
// (R18) wide timer output pin also carries the pwm output by mode
// (R19) three count inputs feed the timers, first shares interrupt pin
// (R20) port 3 gives programmable clock and buzzer outputs
// (R21) software leaves analog-shared pins alone during conversion
`timescale 1ns/1ps
`default_nettype none

module pfm_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         mclk_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] filt_o
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	// a change is taken only once the second and third stages agree
	wire  [W-1:0] agree = ~(s2_reg ^ s3_reg);
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			filt_o <= '0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_o <= (agree & s3_reg) | (~agree & filt_o);
		end
	end
endmodule

module pfm_pin_mux
	import pfm_pkg::*;
#(
	parameter logic [3:0] P6_MASK_PU = 4'h0
) (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic [4:0]  p0_pin_i,
	input  wire logic [7:0]  p1_pin_i,
	input  wire logic [7:0]  p2_pin_i,
	input  wire logic [7:0]  p3_pin_i,
	input  wire logic [7:0]  p4_pin_i,
	input  wire logic [7:0]  p5_pin_i,
	input  wire logic [7:0]  p6_pin_i,
	input  wire logic [2:0]  p0_dir_i,
	input  wire logic [2:0]  p0_latch_i,
	input  wire logic [2:0]  p0_pu_en_i,
	input  wire logic [7:0]  p1_dir_i,
	input  wire logic [7:0]  p1_latch_i,
	input  wire logic [7:0]  p1_pu_en_i,
	input  wire logic [7:0]  p2_dir_i,
	input  wire logic [7:0]  p2_latch_i,
	input  wire logic [7:0]  p2_pu_en_i,
	input  wire logic [7:0]  p3_dir_i,
	input  wire logic [7:0]  p3_latch_i,
	input  wire logic [7:0]  p3_pu_en_i,
	input  wire logic        p4_dir_i,
	input  wire logic [7:0]  p4_latch_i,
	input  wire logic        p4_pu_en_i,
	input  wire logic [7:0]  p5_dir_i,
	input  wire logic [7:0]  p5_latch_i,
	input  wire logic [7:0]  p5_pu_en_i,
	input  wire logic [7:0]  p6_dir_i,
	input  wire logic [7:0]  p6_latch_i,
	input  wire logic [3:0]  p6_pu_en_i,
	input  wire logic [7:0]  analog_inputs_i,
	input  wire logic [1:0]  irq_edge_sel_i,
	input  wire logic        key_flag_clr_i,
	input  wire logic        xmem_en_i,
	input  wire logic        xmem_rd_i,
	input  wire logic        xmem_wr_i,
	input  wire logic [15:0] xmem_addr_i,
	input  wire logic [7:0]  xmem_wdata_i,
	input  wire logic        sio0_en_i,
	input  wire logic        sio0_bus_mode_i,
	input  wire logic [1:0]  sio0_sb_out_i,
	input  wire logic        serial_ch0_data_out_i,
	input  wire logic        serial_ch0_clock_master_i,
	input  wire logic        serial_ch0_clock_out_i,
	input  wire logic        sio1_en_i,
	input  wire logic        sio1_data_out_i,
	input  wire logic        serial_ch1_clock_master_i,
	input  wire logic        serial_ch1_clock_out_i,
	input  wire logic        auto_en_i,
	input  wire logic        auto_transfer_strobe_i,
	input  wire logic [2:0]  to_en_i,
	input  wire logic [2:0]  to_val_i,
	input  wire logic        to0_pwm_mode_i,
	input  wire logic        wide_timer_pwm_i,
	input  wire logic        pcl_en_i,
	input  wire logic        programmable_clock_i,
	input  wire logic        buz_en_i,
	input  wire logic        buzzer_clock_i,
	output logic [4:0]       p0_out_o,
	output logic [4:0]       p0_oe_o,
	output logic [4:0]       p0_pu_o,
	output logic [7:0]       p1_out_o,
	output logic [7:0]       p1_oe_o,
	output logic [7:0]       p1_pu_o,
	output logic [7:0]       p2_out_o,
	output logic [7:0]       p2_oe_o,
	output logic [7:0]       p2_pu_o,
	output logic [7:0]       p3_out_o,
	output logic [7:0]       p3_oe_o,
	output logic [7:0]       p3_pu_o,
	output logic [7:0]       p4_out_o,
	output logic [7:0]       p4_oe_o,
	output logic [7:0]       p4_pu_o,
	output logic [7:0]       p5_out_o,
	output logic [7:0]       p5_oe_o,
	output logic [7:0]       p5_pu_o,
	output logic [7:0]       p6_out_o,
	output logic [7:0]       p6_oe_o,
	output logic [7:0]       p6_pu_o,
	output logic [52:0]      pin_level_o,
	output logic             ext_irq_edge_select_in_o,
	output logic [2:0]       ext_irq_fall_o,
	output logic             key_return_test_flag_o,
	output logic [2:0]       timer_count_in_o,
	output logic             serial_ch0_clock_o,
	output logic             serial_ch1_clock_o,
	output logic             busy_in_o,
	output logic [7:0]       xmem_rdata_o,
	output logic             xmem_done_o,
	output logic             xmem_busy_o
);
	// ****************************************
	// pin sampling and edges
	// ****************************************
	logic [52:0] lvl;
	logic [52:0] lvl_prev_reg;
	logic [2:0]  fill_reg;
	pfm_sync #(.W(LV_W)) u_sync (
		.mclk_i (mclk_i),
		.rstn_i (rstn_i),
		.pin_i  ({p6_pin_i, p5_pin_i, p4_pin_i, p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i}),
		.filt_o (lvl)
	);
	// no edges until the filter holds real pin levels, else reset looks like an edge
	wire        lv_ok = (fill_reg == FILL_CYC);
	wire [52:0] rise  = lvl & ~lvl_prev_reg & {LV_W{lv_ok}};
	wire [52:0] fall  = ~lvl & lvl_prev_reg & {LV_W{lv_ok}};
	wire [7:0]  lv_p3 = lvl[LV_P3 +: 8];
	wire [7:0]  lv_p4 = lvl[LV_P4 +: 8];
	wire [7:0]  lv_p6 = lvl[LV_P6 +: 8];
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			lvl_prev_reg <= '0;
			fill_reg     <= 3'h0;
		end else begin
			lvl_prev_reg <= lvl;
			fill_reg     <= lv_ok ? fill_reg : fill_reg + 3'h1;
		end
	end
	assign pin_level_o        = lvl;
	assign timer_count_in_o   = {lv_p3[4], lv_p3[3], lvl[LV_P0]}; // R19
	assign serial_ch0_clock_o = lvl[LV_P2 + 7]; // R17
	assign serial_ch1_clock_o = lvl[LV_P2 + 2]; // R17
	assign busy_in_o          = lvl[LV_P2 + 4]; // R15

	// ****************************************
	// interrupt edges and key-return flag
	// ****************************************
	logic irq0_reg;
	logic [2:0] irqf_reg;
	logic key_reg;
	wire irq0_hit = (irq_edge_sel_i[EDGE_RISE_BIT] & rise[LV_P0])
		| (irq_edge_sel_i[EDGE_FALL_BIT] & fall[LV_P0]); // R9
	wire p4_is_in = ~p4_dir_i & ~xmem_en_i;
	wire key_hit  = p4_is_in & (|fall[LV_P4 +: 8]);
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			irq0_reg <= 1'b0;
			irqf_reg <= 3'h0;
			key_reg  <= 1'b0;
		end else begin
			irq0_reg <= irq0_hit;
			irqf_reg <= fall[LV_P0 + 1 +: 3];
			// a new edge wins over a clear in the same cycle
			key_reg  <= key_hit | (key_reg & ~key_flag_clr_i); // R5
		end
	end
	assign ext_irq_edge_select_in_o = irq0_reg;
	assign ext_irq_fall_o           = irqf_reg;
	assign key_return_test_flag_o   = key_reg;

	// ****************************************
	// external memory access sequencer
	// ****************************************
	pfm_xst_t    st_reg;
	pfm_xst_t    st_next;
	logic        rd_op_reg;
	logic [15:0] xa_reg;
	logic [7:0]  xw_reg;
	logic [7:0]  xr_reg;
	logic [3:0]  acc_cnt_reg;
	logic        done_reg;
	logic        busy_reg;
	wire x_req   = xmem_en_i & (xmem_rd_i | xmem_wr_i);
	wire wait_on = ~lv_p6[P6_WAIT];
	// the least access length covers the wait input's sampling delay
	wire acc_end = (acc_cnt_reg == ACC_LAST) & ~wait_on; // R14
	always_comb begin
		case (st_reg)
			XS_IDLE: st_next = x_req ? XS_ADDR : XS_IDLE;
			XS_ADDR: st_next = XS_ACC;
			XS_ACC:  st_next = acc_end ? XS_DONE : XS_ACC;
			XS_DONE: st_next = XS_IDLE;
			default: st_next = XS_IDLE;
		endcase
	end
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			st_reg      <= XS_IDLE;
			rd_op_reg   <= 1'b0;
			xa_reg      <= 16'h0000;
			xw_reg      <= PORT_RST;
			xr_reg      <= PORT_RST;
			acc_cnt_reg <= CNT_RST;
			done_reg    <= 1'b0;
			busy_reg    <= 1'b0;
		end else begin
			st_reg      <= st_next;
			acc_cnt_reg <= (st_reg == XS_ACC && acc_cnt_reg != ACC_LAST) ? acc_cnt_reg + 4'h1
				: (st_reg == XS_ACC ? acc_cnt_reg : CNT_RST);
			done_reg    <= (st_reg == XS_ACC) & acc_end;
			busy_reg    <= (st_next != XS_IDLE);
			if (st_reg == XS_IDLE && x_req) begin
				rd_op_reg <= xmem_rd_i;
				xa_reg    <= xmem_addr_i;
				xw_reg    <= xmem_wdata_i;
			end
			if (st_reg == XS_ACC && acc_end && rd_op_reg)
				xr_reg <= lv_p4;
		end
	end
	assign xmem_rdata_o = xr_reg;
	assign xmem_done_o  = done_reg;
	assign xmem_busy_o  = busy_reg;

	// ****************************************
	// pin drive selection
	// ****************************************
	wire st_addr = (st_reg == XS_ADDR);
	wire st_acc  = (st_reg == XS_ACC);
	wire so0_drv = sio0_en_i & ~sio0_bus_mode_i;
	// bus mode: drive low for a zero, release for a one
	wire [1:0] sb_drv = {2{sio0_en_i & sio0_bus_mode_i}} & ~sio0_sb_out_i; // R16
	wire [7:0] a2_oe  = {sio0_en_i & serial_ch0_clock_master_i, so0_drv | sb_drv[1], sb_drv[0], 1'b0,
		auto_en_i, sio1_en_i & serial_ch1_clock_master_i, sio1_en_i, 1'b0}; // R15 R17
	wire [7:0] a2_val = {serial_ch0_clock_out_i, so0_drv & serial_ch0_data_out_i, 1'b0, 1'b0,
		auto_transfer_strobe_i, serial_ch1_clock_out_i, sio1_data_out_i, 1'b0};
	wire to0_val = to0_pwm_mode_i ? wide_timer_pwm_i : to_val_i[0]; // R18
	wire [7:0] a3_oe  = {1'b0, buz_en_i, pcl_en_i, 2'b00, to_en_i}; // R20
	wire [7:0] a3_val = {1'b0, buzzer_clock_i, programmable_clock_i, 2'b00, to_val_i[2:1], to0_val};
	wire [4:0] p0_oe_n  = {1'b0, p0_dir_i, 1'b0}; // R2
	wire [7:0] p2_oe_n  = a2_oe | p2_dir_i; // R3
	wire [7:0] p3_oe_n  = a3_oe | p3_dir_i;
	wire       p4_bus   = st_addr | (st_acc & ~rd_op_reg);
	wire [7:0] p4_oe_n  = xmem_en_i ? {8{p4_bus}} : {8{p4_dir_i}}; // R4 R10
	wire [7:0] p4_val_n = xmem_en_i ? (st_addr ? xa_reg[7:0] : xw_reg) : p4_latch_i; // R10
	wire [7:0] p5_oe_n  = xmem_en_i ? 8'hff : p5_dir_i; // R11
	wire [7:0] p5_val_n = xmem_en_i ? xa_reg[15:8] : p5_latch_i;
	wire [3:0] p6u_bus  = {1'b1, 1'b0, 1'b1, 1'b1};
	wire [3:0] p6u_oe   = xmem_en_i ? p6u_bus : p6_dir_i[7:4];
	wire [3:0] p6u_val  = xmem_en_i ? {st_addr, 1'b0, ~(st_acc & ~rd_op_reg), ~(st_acc & rd_op_reg)}
		: p6_latch_i[7:4]; // R12 R13
	wire [7:0] p6_oe_n  = {p6u_oe, p6_dir_i[3:0] & ~p6_latch_i[3:0]}; // R6
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			p0_oe_o <= 5'h00; // R1
			p1_oe_o <= PORT_RST;
			p2_oe_o <= PORT_RST;
			p3_oe_o <= PORT_RST;
			p4_oe_o <= PORT_RST;
			p5_oe_o <= PORT_RST;
			p6_oe_o <= PORT_RST;
		end else begin
			p0_oe_o <= p0_oe_n;
			p1_oe_o <= p1_dir_i;
			p2_oe_o <= p2_oe_n;
			p3_oe_o <= p3_oe_n;
			p4_oe_o <= p4_oe_n;
			p5_oe_o <= p5_oe_n;
			p6_oe_o <= p6_oe_n;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!rstn_i) begin
			p0_out_o <= 5'h00;
			p1_out_o <= PORT_RST;
			p2_out_o <= PORT_RST;
			p3_out_o <= PORT_RST;
			p4_out_o <= PORT_RST;
			p5_out_o <= PORT_RST;
			p6_out_o <= PORT_RST;
			p0_pu_o  <= 5'h00;
			p1_pu_o  <= PORT_RST;
			p2_pu_o  <= PORT_RST;
			p3_pu_o  <= PORT_RST;
			p4_pu_o  <= PORT_RST;
			p5_pu_o  <= PORT_RST;
			// mask pull-ups are fixed in silicon, so they stand through reset as well
			p6_pu_o  <= {PORT_RST[7:4], P6_MASK_PU}; // R6
		end else begin
			p0_out_o <= {1'b0, p0_latch_i, 1'b0};
			p1_out_o <= p1_latch_i;
			p2_out_o <= (a2_oe & a2_val) | (~a2_oe & p2_latch_i);
			p3_out_o <= (a3_oe & a3_val) | (~a3_oe & p3_latch_i);
			p4_out_o <= p4_val_n;
			p5_out_o <= p5_val_n;
			p6_out_o <= {p6u_val, 4'h0};
			p0_pu_o  <= {1'b0, p0_pu_en_i & ~p0_dir_i, 1'b0}; // R2
			p1_pu_o  <= p1_pu_en_i & ~p1_dir_i & ~analog_inputs_i; // R8
			p2_pu_o  <= p2_pu_en_i & ~p2_oe_n; // R3
			p3_pu_o  <= p3_pu_en_i & ~p3_oe_n;
			p4_pu_o  <= {8{p4_pu_en_i}} & ~p4_oe_n; // R4
			p5_pu_o  <= p5_pu_en_i & ~p5_oe_n;
			p6_pu_o  <= {p6_pu_en_i & ~p6u_oe, P6_MASK_PU}; // R6
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_reset_all_inputs: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R1
		$rose(rstn_i) |-> ({p0_oe_o, p1_oe_o, p2_oe_o, p3_oe_o, p4_oe_o, p5_oe_o, p6_oe_o} == '0))
		else $error("pin driven right after reset");
	a_p0_input_only: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R2
		!p0_oe_o[0] && !p0_oe_o[4] && !p0_pu_o[0] && !p0_pu_o[4])
		else $error("input-only pin driven or pulled");
	a_analog_no_pull: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R8
		(analog_inputs_i != 8'h00) |=> ((p1_pu_o & $past(analog_inputs_i)) == 8'h00))
		else $error("pull-up on analog input");
	a_key_flag_set: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R5
		key_hit |=> key_return_test_flag_o ##1 (key_return_test_flag_o || $past(key_flag_clr_i)))
		else $error("key-return flag missed edge");
	a_p4_group_dir: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R4
		(p4_oe_o == 8'h00) || (p4_oe_o == 8'hff))
		else $error("port 4 direction split");
	a_strobe_order: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R12
		(st_addr && xmem_en_i) ##1 xmem_en_i |-> p6_out_o[P6_ADDRESS_LATCH_STROBE] && p5_out_o == xa_reg[15:8]
		##1 !p6_out_o[P6_ADDRESS_LATCH_STROBE] && (p6_out_o[P6_RD] != p6_out_o[P6_WR]))
		else $error("address strobe or access strobe out of order");
	a_wait_holds: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R14
		(st_acc && wait_on) |=> st_acc && !xmem_done_o)
		else $error("access ended during wait");
	a_p6_open_drain: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R6
		(p6_out_o[3:0] == 4'h0) && (p6_pu_o[3:0] == P6_MASK_PU))
		else $error("open-drain pin drives high");
	a_irq0_edge: assert property (@(posedge mclk_i) disable iff (!rstn_i) // R9
		irq0_hit |=> ext_irq_edge_select_in_o ##1 (!ext_irq_edge_select_in_o || $past(irq0_hit)))
		else $error("first interrupt edge missed");
endmodule

`default_nettype wire

// ---- hw/pfm_pkg.sv ----
package pfm_pkg;
	// ****************************************
	// pin level vector layout
	// ****************************************
	localparam int unsigned LV_W  = 53;
	localparam int unsigned LV_P0 = 0;
	localparam int unsigned LV_P1 = 5;
	localparam int unsigned LV_P2 = 13;
	localparam int unsigned LV_P3 = 21;
	localparam int unsigned LV_P4 = 29;
	localparam int unsigned LV_P5 = 37;
	localparam int unsigned LV_P6 = 45;
	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned EDGE_RISE_BIT = 0;
	localparam int unsigned EDGE_FALL_BIT = 1;
	localparam int unsigned P6_RD   = 4;
	localparam int unsigned P6_WR   = 5;
	localparam int unsigned P6_WAIT = 6;
	localparam int unsigned P6_ADDRESS_LATCH_STROBE = 7;
	// ****************************************
	// reset values and timing counts
	// ****************************************
	localparam logic [7:0] PORT_RST  = 8'h00;
	localparam logic [2:0] FILL_CYC  = 3'h5;
	localparam logic [3:0] ACC_LAST  = 4'h5;
	localparam logic [3:0] CNT_RST   = 4'h0;
	typedef enum logic [3:0] {
		XS_IDLE = 4'b0001,
		XS_ADDR = 4'b0010,
		XS_ACC  = 4'b0100,
		XS_DONE = 4'b1000
	} pfm_xst_t;
endpackage

// ---- tb/pfm_board.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// external memory and wait source on ports 4 to 6
// ********
module pfm_board (
	input  wire logic       mclk_i,
	input  wire logic       sel_i,
	input  wire logic [7:0] p4_i,
	input  wire logic [7:0] p5_i,
	input  wire logic [7:0] p6_i,
	input  wire logic [3:0] wlen_i,
	output logic      [7:0] d_o,
	output logic            wait_n_o,
	output logic      [7:0] wbyte_o
);
	logic [15:0] addr_reg;
	logic [7:0]  last_reg;
	logic [3:0]  cnt_reg;
	wire  logic       rd_on = sel_i && !p6_i[4];
	wire  logic [7:0] mem_q = addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h5a;
	initial begin
		addr_reg = 16'h0000;
		last_reg = 8'h00;
		cnt_reg  = 4'h0;
		wbyte_o  = 8'h00;
	end
	// released bus shows the inverse of the last byte, never a stale copy
	assign d_o = rd_on ? mem_q : ~last_reg;
	// wait is raised while the address is still latched, so it lands inside the access
	assign wait_n_o = !(sel_i && p6_i[7] && wlen_i != 4'h0) && cnt_reg == 4'h0;
	always @(posedge mclk_i) begin
		if (rd_on)
			last_reg <= mem_q;
		if (sel_i && p6_i[7])
			addr_reg <= {p5_i, p4_i};
		if (sel_i && !p6_i[5])
			wbyte_o <= p4_i;
		if (sel_i && p6_i[7])
			cnt_reg <= wlen_i;
		else if (cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
	end
endmodule
`default_nettype wire

// ---- tb/pfm_pin_mux_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux_test;
	import pfm_pkg::*;
	logic        mclk_i, rstn_i, p4_dir_i, p4_pu_en_i, key_flag_clr_i, xmem_en_i, xmem_rd_i, xmem_wr_i;
	logic        sio0_en_i, sio0_bus_mode_i, serial_ch0_data_out_i, serial_ch0_clock_master_i, serial_ch0_clock_out_i, sio1_en_i;
	logic        sio1_data_out_i, serial_ch1_clock_master_i, serial_ch1_clock_out_i, auto_en_i, auto_transfer_strobe_i, pcl_en_i;
	logic        to0_pwm_mode_i, wide_timer_pwm_i, programmable_clock_i, buz_en_i, buzzer_clock_i;
	logic        ext_irq_edge_select_in_o, key_return_test_flag_o, serial_ch0_clock_o, serial_ch1_clock_o;
	logic        busy_in_o, xmem_done_o, xmem_busy_o, wait_n;
	logic [1:0]  irq_edge_sel_i, sio0_sb_out_i;
	logic [2:0]  p0_dir_i, p0_latch_i, p0_pu_en_i, to_en_i, to_val_i, ext_irq_fall_o, timer_count_in_o;
	logic [3:0]  p6_pu_en_i, wlen;
	logic [4:0]  p0_out_o, p0_oe_o, p0_pu_o, e0;
	logic [7:0]  p1_dir_i, p1_latch_i, p1_pu_en_i, p2_dir_i, p2_latch_i, p2_pu_en_i, p3_dir_i, p3_latch_i;
	logic [7:0]  p3_pu_en_i, p4_latch_i, p5_dir_i, p5_latch_i, p5_pu_en_i, p6_dir_i, p6_latch_i;
	logic [7:0]  analog_inputs_i, xmem_wdata_i, xmem_rdata_o, p1_out_o, p1_oe_o, p1_pu_o, p2_out_o, p2_oe_o;
	logic [7:0]  p2_pu_o, p3_out_o, p3_oe_o, p3_pu_o, p4_out_o, p4_oe_o, p4_pu_o, p5_out_o, p5_oe_o, p5_pu_o;
	logic [7:0]  p6_out_o, p6_oe_o, p6_pu_o, e1, e2, e3, e4, e5, e6, bd4, wbyte;
	logic [15:0] xmem_addr_i;
	logic [52:0] pin_level_o;
	wire  logic [4:0] p0_pin_i;
	wire  logic [7:0] p1_pin_i, p2_pin_i, p3_pin_i, p4_pin_i, p5_pin_i, p6_pin_i;
	int          n_errors, tests_run, seed, n, r, f;
	// ********
	// pin wires: driver wins, else pull-up, else the outside level
	// ********
	assign p0_pin_i = p0_oe_o & p0_out_o | ~p0_oe_o & (p0_pu_o | e0);
	assign p1_pin_i = p1_oe_o & p1_out_o | ~p1_oe_o & (p1_pu_o | e1);
	assign p2_pin_i = p2_oe_o & p2_out_o | ~p2_oe_o & (p2_pu_o | e2);
	assign p3_pin_i = p3_oe_o & p3_out_o | ~p3_oe_o & (p3_pu_o | e3);
	assign p4_pin_i = p4_oe_o & p4_out_o | ~p4_oe_o & (p4_pu_o | (xmem_en_i ? bd4 : e4));
	assign p5_pin_i = p5_oe_o & p5_out_o | ~p5_oe_o & (p5_pu_o | e5);
	assign p6_pin_i = p6_oe_o & p6_out_o | ~p6_oe_o & (p6_pu_o | {e6[7], xmem_en_i ? wait_n : e6[6], e6[5:0]});
	pfm_pin_mux #(.P6_MASK_PU(4'ha)) i_dut (.*);
	pfm_board i_board (.mclk_i(mclk_i), .sel_i(xmem_en_i), .p4_i(p4_pin_i), .p5_i(p5_pin_i), .p6_i(p6_pin_i),
		.wlen_i(wlen), .d_o(bd4), .wait_n_o(wait_n), .wbyte_o(wbyte));
	always #12.5 mclk_i = ~mclk_i;
	// ********
	// helpers
	// ********
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk_i);
	endtask
	task automatic pulses(output int c);
		c = 0;
		repeat (10) begin
			@(negedge mclk_i);
			if (ext_irq_edge_select_in_o === 1'b1)
				c++;
		end
	endtask
	function automatic logic [7:0] pu_exp(input logic [7:0] u, input logic [7:0] d, input logic [7:0] a);
		return u & ~d & ~a;
	endfunction
	// no conversion runs here, so analog-shared pins may move freely; sub-osc pin is a plain input
	task rp;
		{p0_dir_i, p0_latch_i, p0_pu_en_i, p4_dir_i, p4_latch_i, p4_pu_en_i} = $random(seed);
		{p1_dir_i, p1_latch_i, p1_pu_en_i} = $random(seed);
		{p2_dir_i, p2_latch_i, p2_pu_en_i} = $random(seed);
		{p3_dir_i, p3_latch_i, p3_pu_en_i} = $random(seed);
		{p5_dir_i, p5_latch_i, p5_pu_en_i} = $random(seed);
		{p6_dir_i, p6_latch_i, p6_pu_en_i, analog_inputs_i} = $random(seed);
		{e0, e1, e2} = $random(seed);
		{e3, e4, e5, e6} = $random(seed);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// generous bound: the sequence needs under 2000 cycles
	initial begin
		#500000;
		n_errors++;
		finish_test();
	end
	initial begin
		{mclk_i, rstn_i, n_errors, tests_run, seed} = {2'b00, 32'd0, 32'd0, 32'd56};
		{key_flag_clr_i, xmem_en_i, xmem_rd_i, xmem_wr_i, xmem_addr_i, xmem_wdata_i, wlen, irq_edge_sel_i} = '0;
		{sio0_en_i, sio0_bus_mode_i, serial_ch0_data_out_i, serial_ch0_clock_master_i, serial_ch0_clock_out_i, sio1_en_i} = '0;
		{sio1_data_out_i, serial_ch1_clock_master_i, serial_ch1_clock_out_i, auto_en_i, auto_transfer_strobe_i, pcl_en_i} = '0;
		{to0_pwm_mode_i, wide_timer_pwm_i, programmable_clock_i, buz_en_i, buzzer_clock_i} = '0;
		{sio0_sb_out_i, to_en_i, to_val_i} = '0;
		rp();
		cyc(12);
		chk("rst oe", 53'h0, {p0_oe_o, p1_oe_o, p2_oe_o, p3_oe_o, p4_oe_o, p5_oe_o, p6_oe_o});
		chk("rst pu", {49'h0, 4'ha, 1'b0}, {p0_pu_o, p1_pu_o, p2_pu_o, p3_pu_o, p4_pu_o, p5_pu_o, p6_pu_o, key_return_test_flag_o});
		rstn_i = 1'b1;
		cyc(6);
		for (int i = 0; i < 20; i++) begin
			rp();
			cyc(2);
			chk("p0", {1'b0, p0_dir_i, 2'b00, p0_pu_en_i & ~p0_dir_i, 1'b0}, {p0_oe_o, p0_pu_o});
			chk("p1 oe", {p1_dir_i, p1_latch_i & p1_dir_i}, {p1_oe_o, p1_out_o & p1_oe_o});
			chk("p1 pu", pu_exp(p1_pu_en_i, p1_dir_i, analog_inputs_i), p1_pu_o);
			chk("p235 oe", {p2_dir_i, p3_dir_i, p5_dir_i}, {p2_oe_o, p3_oe_o, p5_oe_o});
			chk("p235 pu", {pu_exp(p2_pu_en_i, p2_dir_i, 8'h00), pu_exp(p3_pu_en_i, p3_dir_i, 8'h00),
				pu_exp(p5_pu_en_i, p5_dir_i, 8'h00)}, {p2_pu_o, p3_pu_o, p5_pu_o});
			chk("p4", {{8{p4_dir_i}}, {8{p4_pu_en_i & ~p4_dir_i}}}, {p4_oe_o, p4_pu_o});
			chk("p6 oe", {p6_dir_i[7:4], p6_dir_i[3:0] & ~p6_latch_i[3:0]}, p6_oe_o);
			chk("outs", {1'b0, p0_latch_i & p0_dir_i, 1'b0, p2_latch_i & p2_dir_i, p3_latch_i & p3_dir_i,
				p4_latch_i & {8{p4_dir_i}}, p5_latch_i & p5_dir_i, p6_latch_i[7:4] & p6_dir_i[7:4]},
				{p0_out_o & p0_oe_o, p2_out_o & p2_oe_o, p3_out_o & p3_oe_o, p4_out_o & p4_oe_o,
				p5_out_o & p5_oe_o, p6_out_o[7:4] & p6_oe_o[7:4]});
			chk("p6 pu", {p6_pu_en_i & ~p6_dir_i[7:4], 4'ha, 4'h0}, {p6_pu_o, p6_out_o[3:0] & p6_oe_o[3:0]});
			cyc(4);
			chk("levels", {p6_pin_i, p5_pin_i, p4_pin_i, p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i}, pin_level_o);
		end
		{p4_dir_i, p4_pu_en_i, e4} = {2'b00, 8'hff};
		cyc(8);
		key_flag_clr_i = 1'b1;
		cyc(1);
		key_flag_clr_i = 1'b0;
		cyc(1);
		chk("key clr", 1'b0, key_return_test_flag_o);
		r = $random(seed) & 7;
		e4[r] = 1'b0;
		cyc(7);
		chk("key set", 1'b1, key_return_test_flag_o);
		{p0_dir_i, p0_pu_en_i, e0[3:1]} = {6'h00, 3'h7};
		cyc(8);
		e0[3:1] = 3'h0;
		f = 0;
		repeat (10) begin
			cyc(1);
			if (ext_irq_fall_o === 3'h7)
				f++;
		end
		chk("fall irq", 1, f);
		for (int s = 1; s < 4; s++) begin
			irq_edge_sel_i = s[1:0];
			e0[0] = 1'b0;
			cyc(8);
			e0[0] = 1'b1;
			pulses(r);
			chk("count in", 1'b1, timer_count_in_o[0]);
			e0[0] = 1'b0;
			pulses(f);
			chk("irq edges", {1'b0, s[0], 1'b0, s[1]}, {r[1:0], f[1:0]});
		end
		{p2_dir_i, p3_dir_i} = '0;
		{sio0_en_i, serial_ch0_clock_master_i, serial_ch0_clock_out_i, sio0_bus_mode_i, sio0_sb_out_i} = 6'b111110;
		{sio1_en_i, auto_en_i, auto_transfer_strobe_i, serial_ch1_clock_master_i} = 4'b1110;
		{to_en_i, to_val_i, wide_timer_pwm_i, pcl_en_i, programmable_clock_i, buz_en_i, buzzer_clock_i} = 11'h7de;
		for (int m = 0; m < 2; m++) begin
			to0_pwm_mode_i = m[0];
			{sio0_bus_mode_i, serial_ch0_data_out_i, serial_ch1_clock_master_i} = {!m[0], m[0], m[0]};
			cyc(6);
			chk("p2 alt", m[0] ? 16'hccc8 : 16'ha888, {p2_oe_o, p2_out_o & p2_oe_o} & 16'hecec);
			chk("p3 alt", {8'h63, 7'h11, m[0]}, {p3_oe_o, p3_out_o & p3_oe_o} & 16'h6363);
			chk("alt in", {p2_pin_i[7], p2_pin_i[2], p2_pin_i[4], p3_pin_i[4:3], p0_pin_i[0]},
				{serial_ch0_clock_o, serial_ch1_clock_o, busy_in_o, timer_count_in_o});
		end
		{p4_dir_i, p4_pu_en_i, p6_dir_i, p6_pu_en_i, xmem_en_i} = 15'h0001;
		cyc(6);
		for (int i = 0; i < 4; i++) begin
			xmem_addr_i = $random(seed);
			xmem_wdata_i = $random(seed);
			wlen = i[1] ? 4'h6 : 4'h0;
			{xmem_rd_i, xmem_wr_i} = {!i[0], i[0]};
			cyc(1);
			{xmem_rd_i, xmem_wr_i, n} = '0;
			chk("busy", 1'b1, xmem_busy_o);
			while (xmem_done_o !== 1'b1 && n < 40) begin
				cyc(1);
				n++;
			end
			chk("xmem cycles", 1'b1, i[1] ? (n > ACC_LAST + 2 && n < 40) : (n == ACC_LAST + 2));
			cyc(3);
			chk("idle", 1'b0, xmem_busy_o);
			if (i[0])
				chk("wbyte", xmem_wdata_i, wbyte);
			else
				chk("rdata", xmem_addr_i[7:0] ^ xmem_addr_i[15:8] ^ 8'h5a, xmem_rdata_o);
		end
		finish_test();
	end
endmodule
`default_nettype wire
